/* File: common/cmt_pkg.sv */
/*
 * Shared constants of the charger mode and thermistor control block: register indices,
 * field positions, reset values, thermistor thresholds and timing figures.
 * Assumes an 8-bit register port addressed by register index and a 25 MHz core clock.
 */
package cmt_pkg;

	// ---------------------------------------------------------------
	// Register indices and widths
	// ---------------------------------------------------------------
	localparam int CMT_AW = 4;
	localparam int CMT_DW = 8;
	localparam logic [3:0] CMT_REG_CTRL = 4'h1;
	localparam logic [3:0] CMT_REG_FLOAT = 4'h2;
	localparam logic [3:0] CMT_REG_CURRENT = 4'h4;
	localparam logic [3:0] CMT_REG_LEVEL = 4'h5;
	localparam logic [3:0] CMT_REG_SAFETY = 4'h6;
	localparam logic [3:0] CMT_REG_MONITOR = 4'hA;
	localparam logic [3:0] CMT_REG_THERM = 4'hC;
	localparam logic [3:0] CMT_REG_WDOG = 4'hD;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CMT_CTRL_HZ_BIT = 1;
	localparam int CMT_CTRL_CHGDIS_BIT = 2;
	localparam int CMT_CTRL_TERMEN_BIT = 3;
	localparam int CMT_CTRL_LOWBAT_LSB = 4;
	localparam int CMT_CTRL_INLIM_LSB = 6;
	localparam int CMT_FLOAT_LSB = 2;
	localparam int CMT_CUR_TERM_LSB = 0;
	localparam int CMT_CUR_CHG_LSB = 3;
	localparam int CMT_CUR_RESET_BIT = 7;
	localparam int CMT_LEVEL_EOC_BIT = 4;
	localparam int CMT_LEVEL_IOLVL_BIT = 5;
	localparam int CMT_THERM_VALID_BIT = 4;
	localparam int CMT_THERM_TDIS_BIT = 5;
	localparam int CMT_WDOG_KICK_BIT = 0;
	localparam int CMT_WDOG_DIS_BIT = 1;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] CMT_CTRL_RST = 8'h04;
	localparam logic [7:0] CMT_FLOAT_RST = 8'h00;
	localparam logic [7:0] CMT_CURRENT_RST = 8'h00;
	localparam logic [7:0] CMT_LEVEL_RST = 8'h00;
	localparam logic [7:0] CMT_SAFETY_RST = 8'h00;
	localparam logic CMT_WDOG_DIS_RST = 1'b1;

	// ---------------------------------------------------------------
	// Thermistor thresholds, in tenths of a percent of the reference
	// ---------------------------------------------------------------
	localparam int CMT_RATIO_W = 10;
	localparam logic [9:0] CMT_THRESH_PERMILLE [0:3] = '{10'd739, 10'd646, 10'd329, 10'd233};
	localparam logic [3:0] CMT_ZONE_COLD = 4'h0;
	localparam logic [3:0] CMT_ZONE_COOL = 4'h1;
	localparam logic [3:0] CMT_ZONE_WARM = 4'h7;
	localparam logic [3:0] CMT_ZONE_HOT = 4'hF;

	// ---------------------------------------------------------------
	// Charge current and float voltage scaling
	// ---------------------------------------------------------------
	localparam logic [10:0] CMT_ICHG_BASE_MA = 11'd350;
	localparam logic [10:0] CMT_ICHG_STEP_MA = 11'd100;
	localparam logic [10:0] CMT_ICHG_LOW_MA = 11'd650;
	localparam logic [10:0] CMT_ICHG_FLOOR_MA = 11'd340;
	localparam logic [12:0] CMT_VFLT_BASE_MV = 13'd3500;
	localparam logic [12:0] CMT_VFLT_STEP_MV = 13'd20;
	localparam logic [12:0] CMT_VFLT_DERATE_MV = 13'd4000;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CMT_CLK_HZ = 25_000_000;
	localparam int CMT_WDOG_PERIOD_S = 32;
	localparam int CMT_THERM_PERIOD_S = 1;
	localparam int CMT_WDOG_CYCLES = CMT_WDOG_PERIOD_S * CMT_CLK_HZ;
	localparam int CMT_THERM_CYCLES = CMT_THERM_PERIOD_S * CMT_CLK_HZ;
	localparam int CMT_CNT_W = 30;

	typedef enum logic [1:0] {CMT_CHG_OFF, CMT_CHG_MEASURE, CMT_CHG_ON} cmt_chg_e;

endpackage : cmt_pkg

/* File: logic/cmt_charger_control.sv */
/*
 * Charger mode control and battery thermistor monitor, with an 8-bit register port.
 * Assumes analog comparator levels arrive asynchronously on pins, and that a converter on
 * the same clock answers each thermistor sample request with one valid pulse and a ratio.
 */
`timescale 1ns/10ps

module cmt_charger_control #(
	parameter int WDOG_CYCLES = cmt_pkg::CMT_WDOG_CYCLES,
	parameter int THERM_CYCLES = cmt_pkg::CMT_THERM_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [cmt_pkg::CMT_AW-1:0] regAddr,
	input wire logic [cmt_pkg::CMT_DW-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [cmt_pkg::CMT_DW-1:0] regRdata,
	input wire logic busValidPin,
	input wire logic busAboveMinPin,
	input wire logic busBelowSleepPin,
	input wire logic batBelowLowPin,
	input wire logic disablePin,
	input wire logic dieHotPin,
	input wire logic thermShortPin,
	input wire logic safetyTimerExpired,
	input wire logic chargeDone,
	input wire logic paramResetReq,
	output logic thermSampleReq,
	input wire logic thermSampleValid,
	input wire logic [cmt_pkg::CMT_RATIO_W-1:0] thermRatio,
	output logic buckEnable,
	output logic chargeEnable,
	output logic batterySwitchOn,
	output logic supplementSwitchOn,
	output logic reverseBlockOn,
	output logic [10:0] chargeCurrentMa,
	output logic [12:0] floatVoltageMv,
	output logic watchdogExpired
);
	import cmt_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] pinRaw;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	logic [NSYNC-1:0] s3_q;
	logic [NSYNC-1:0] pin_q;
	assign pinRaw = {thermShortPin, dieHotPin, disablePin, batBelowLowPin,
		busBelowSleepPin, busAboveMinPin, busValidPin};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pinRaw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						pin_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	wire busValid = pin_q[0];
	wire busAboveMin = pin_q[1];
	wire busBelowSleep = pin_q[2];
	wire batLow = pin_q[3];
	wire disLevel = pin_q[4];
	wire dieHot = pin_q[5];
	wire thermShort = pin_q[6];

	// ---------------------------------------------------------------
	// Register state and decode
	// ---------------------------------------------------------------
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] float_q, float_d;
	logic [7:0] cur_q, cur_d;
	logic [7:0] level_q, level_d;
	logic [7:0] safety_q, safety_d;
	logic tempDis_q, tempDis_d;
	logic wdDis_q, wdDis_d;
	logic [3:0] zone_q;
	logic thermValid_q;
	logic [7:0] rdata_q;
	logic [CMT_CNT_W-1:0] wdCount_q;
	logic [CMT_CNT_W-1:0] secCount_q;
	cmt_chg_e state_q, state_d;

	wire wrCtrl = regWr && regAddr == CMT_REG_CTRL;
	wire wrFloat = regWr && regAddr == CMT_REG_FLOAT;
	wire wrCur = regWr && regAddr == CMT_REG_CURRENT;
	wire wrLevel = regWr && regAddr == CMT_REG_LEVEL;
	wire wrSafety = regWr && regAddr == CMT_REG_SAFETY;
	wire wrTherm = regWr && regAddr == CMT_REG_THERM;
	wire wrWdog = regWr && regAddr == CMT_REG_WDOG;
	wire softReset = wrCur && regWdata[CMT_CUR_RESET_BIT];
	wire wdKick = wrWdog && regWdata[CMT_WDOG_KICK_BIT];

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	wire hzRequest = ctrl_q[CMT_CTRL_HZ_BIT];
	wire chgDisable = ctrl_q[CMT_CTRL_CHGDIS_BIT];
	wire hiZ = hzRequest || disLevel;
	wire sleepMode = busAboveMin && busBelowSleep;
	wire idleCond = safetyTimerExpired || chargeDone || chgDisable;
	wire standbyMode = !busValid || hiZ || dieHot;
	// Clearing the request or lowering the pin drops standby and lets charging restart.
	wire chargeWanted = !standbyMode && !sleepMode && !idleCond;

	// The watchdog freezes rather than clears so a brief high-impedance spell costs no time.
	wire wdRun = !wdDis_q && !(hiZ && !batLow);
	wire wdExpire = wdRun && wdCount_q == '0;
	wire lowBatCond = hiZ && batLow;
	wire lowBatReset = lowBatCond && (wdDis_q ? 1'b1 : wdExpire);
	wire regReset = softReset || lowBatReset;
	wire ceAfterReset = !(softReset && busValid && batLow);

	// ---------------------------------------------------------------
	// Register next values
	// ---------------------------------------------------------------
	// Reset wins over parameter restore, which wins over a host write.
	wire [7:0] ctrlParam = {CMT_CTRL_RST[7:4], ctrl_q[3:0]};
	wire [7:0] ctrlReset = {CMT_CTRL_RST[7:3], ceAfterReset, CMT_CTRL_RST[1:0]};
	assign ctrl_d = regReset ? ctrlReset :
		paramResetReq ? ctrlParam :
		wrCtrl ? {regWdata[7:1], 1'b0} : ctrl_q;
	assign float_d = (regReset || paramResetReq) ? CMT_FLOAT_RST :
		wrFloat ? {regWdata[7:2], 2'b00} : float_q;
	assign cur_d = (regReset || paramResetReq) ? CMT_CURRENT_RST :
		wrCur ? {1'b0, regWdata[6:0]} : cur_q;
	assign level_d = regReset ? CMT_LEVEL_RST :
		wrLevel ? {2'b00, regWdata[5:4], 4'h0} : level_q;
	assign safety_d = paramResetReq ? CMT_SAFETY_RST :
		wrSafety ? regWdata : safety_q;
	assign tempDis_d = regReset ? 1'b0 :
		wrTherm ? regWdata[CMT_THERM_TDIS_BIT] : tempDis_q;
	assign wdDis_d = regReset ? CMT_WDOG_DIS_RST :
		wrWdog ? regWdata[CMT_WDOG_DIS_BIT] : wdDis_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= CMT_CTRL_RST;
			float_q <= CMT_FLOAT_RST;
			cur_q <= CMT_CURRENT_RST;
			level_q <= CMT_LEVEL_RST;
			safety_q <= CMT_SAFETY_RST;
			tempDis_q <= 1'b0;
			wdDis_q <= CMT_WDOG_DIS_RST;
		end else begin
			ctrl_q <= ctrl_d;
			float_q <= float_d;
			cur_q <= cur_d;
			level_q <= level_d;
			safety_q <= safety_d;
			tempDis_q <= tempDis_d;
			wdDis_q <= wdDis_d;
		end
	end

	// ---------------------------------------------------------------
	// Watchdog
	// ---------------------------------------------------------------
	localparam logic [CMT_CNT_W-1:0] WD_LOAD = CMT_CNT_W'(WDOG_CYCLES - 1);
	wire [CMT_CNT_W-1:0] wdCount_d = (wdDis_q || wdKick || regReset || wdExpire) ? WD_LOAD :
		wdRun ? wdCount_q - 1'b1 : wdCount_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			wdCount_q <= WD_LOAD;
		end else begin
			wdCount_q <= wdCount_d;
		end
	end

	// ---------------------------------------------------------------
	// Thermistor schedule and zone coding
	// ---------------------------------------------------------------
	localparam logic [CMT_CNT_W-1:0] SEC_LOAD = CMT_CNT_W'(THERM_CYCLES - 1);
	wire secTick = state_q == CMT_CHG_ON && secCount_q == '0;
	logic [3:0] zoneNew;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_zone
			// A warmer battery gives a lower ratio, so each passed threshold sets one more bit.
			assign zoneNew[gi] = thermRatio < CMT_THRESH_PERMILLE[gi];
		end
	endgenerate

	always_comb begin
		state_d = state_q;
		case (state_q)
			CMT_CHG_OFF: begin
				if (chargeWanted) begin
					state_d = thermShort ? CMT_CHG_ON : CMT_CHG_MEASURE;
				end
			end
			CMT_CHG_MEASURE: begin
				if (!chargeWanted) begin
					state_d = CMT_CHG_OFF;
				end else if (thermSampleValid || thermShort) begin
					state_d = CMT_CHG_ON;
				end
			end
			CMT_CHG_ON: begin
				if (!chargeWanted) begin
					state_d = CMT_CHG_OFF;
				end
			end
			default: begin
				state_d = CMT_CHG_OFF;
			end
		endcase
	end

	assign thermSampleReq = !thermShort && chargeWanted &&
		((state_q == CMT_CHG_OFF) || secTick);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= CMT_CHG_OFF;
			secCount_q <= SEC_LOAD;
			zone_q <= CMT_ZONE_COLD;
			thermValid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			secCount_q <= (state_q != CMT_CHG_ON || secTick) ? SEC_LOAD : secCount_q - 1'b1;
			if (thermShort) begin
				zone_q <= CMT_ZONE_COLD;
				thermValid_q <= 1'b0;
			end else if (thermSampleValid) begin
				zone_q <= zoneNew;
				thermValid_q <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Charge derating and power switches
	// ---------------------------------------------------------------
	wire tempActive = thermValid_q && !tempDis_q;
	wire zoneStop = zone_q == CMT_ZONE_COLD || zone_q == CMT_ZONE_HOT;
	wire zoneDerate = zone_q == CMT_ZONE_COOL || zone_q == CMT_ZONE_WARM;
	wire chargeOk = state_q == CMT_CHG_ON && !(tempActive && zoneStop);
	wire derate = tempActive && zoneDerate;
	wire [10:0] progMa = CMT_ICHG_BASE_MA + 11'(cur_q[6:3]) * CMT_ICHG_STEP_MA;
	wire [12:0] progMv = CMT_VFLT_BASE_MV + 13'(float_q[7:2]) * CMT_VFLT_STEP_MV;
	wire [10:0] derMa = (progMa < CMT_ICHG_LOW_MA) ? CMT_ICHG_FLOOR_MA : progMa >> 1;

	always_ff @(posedge clk) begin
		if (rst) begin
			buckEnable <= 1'b0;
			chargeEnable <= 1'b0;
			batterySwitchOn <= 1'b1;
			supplementSwitchOn <= 1'b1;
			reverseBlockOn <= 1'b0;
			chargeCurrentMa <= '0;
			floatVoltageMv <= '0;
			watchdogExpired <= 1'b0;
		end else begin
			buckEnable <= !standbyMode && !sleepMode;
			chargeEnable <= chargeOk;
			batterySwitchOn <= chargeOk || hiZ || !busValid;
			supplementSwitchOn <= hiZ || !busValid;
			reverseBlockOn <= sleepMode;
			chargeCurrentMa <= derate ? derMa : progMa;
			floatVoltageMv <= derate ? CMT_VFLT_DERATE_MV : progMv;
			watchdogExpired <= wdExpire;
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	// The monitor word is built from present levels so a read sees the state of that cycle.
	wire [7:0] monitorWord = {2'b00, chargeOk, sleepMode, idleCond, standbyMode, hiZ, busValid};
	wire [7:0] thermWord = {2'b00, tempDis_q, thermValid_q, zone_q};
	wire [7:0] wdogWord = {6'h00, wdDis_q, 1'b0};
	wire [7:0] rdMux = regAddr == CMT_REG_CTRL ? ctrl_q :
		regAddr == CMT_REG_FLOAT ? float_q :
		regAddr == CMT_REG_CURRENT ? cur_q :
		regAddr == CMT_REG_LEVEL ? level_q :
		regAddr == CMT_REG_SAFETY ? safety_q :
		regAddr == CMT_REG_MONITOR ? monitorWord :
		regAddr == CMT_REG_THERM ? thermWord :
		regAddr == CMT_REG_WDOG ? wdogWord : 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= regRd ? rdMux : 8'h00;
		end
	end
	assign regRdata = rdata_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence sampleAsked;
		state_q == CMT_CHG_OFF && thermSampleReq;
	endsequence
	sequence sampleAnswered;
		state_q == CMT_CHG_MEASURE && thermSampleValid && chargeWanted;
	endsequence

	reset_keeps_ce_a: assert property (softReset && !(busValid && batLow) |=> chgDisable)
		else $error("charge disable cleared by reset without low battery");
	reset_clears_hz_a: assert property (softReset |=> !hzRequest && !tempDis_q)
		else $error("register reset left request or temperature disable set");
	hiz_buck_off_a: assert property (hiZ && !rst |=> ##1 (!buckEnable || !$past(hiZ)))
		else $error("buck enabled in high impedance");
	lowbat_reset_a: assert property (lowBatCond && wdDis_q |=> chgDisable && !hzRequest)
		else $error("low battery high impedance did not reset registers");
	wd_gate_a: assert property (lowBatCond && !wdDis_q && !wdExpire && !softReset && !wrWdog
		|=> !wdDis_q)
		else $error("watchdog enabled reset happened before expiry");
	wd_freeze_a: assert property (!wdDis_q && hiZ && !batLow && !wdKick && !regReset
		|=> $stable(wdCount_q))
		else $error("watchdog advanced in high impedance");
	measure_first_a: assert property (sampleAsked |=> state_q == CMT_CHG_MEASURE)
		else $error("charging entered without thermistor sample");
	measure_done_a: assert property (sampleAnswered |=> state_q == CMT_CHG_ON ##1 !thermShort
		|| chargeEnable || (tempActive && zoneStop))
		else $error("sample result did not start charging");
	zone_code_a: assert property (zone_q inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
		else $error("zone bits not a thermometer code");
	short_clear_a: assert property (thermShort |=> zone_q == CMT_ZONE_COLD && !thermValid_q)
		else $error("shorted thermistor left zone status");
	zone_stop_a: assert property (tempActive && zoneStop |=> !chargeEnable)
		else $error("charging outside temperature window");
	floor_current_a: assert property (derate && progMa < CMT_ICHG_LOW_MA
		|=> chargeCurrentMa == CMT_ICHG_FLOOR_MA)
		else $error("derated low current not limited");

endmodule : cmt_charger_control

/* File: verif/cmt_therm_model.sv */
/*
 * Thermistor converter model: answers each sample request taken while idle with one valid pulse and a ratio.
 * Assumes the control block samples requests and results on the same rising clock edge.
 */
`timescale 1ns/10ps
module cmt_therm_model (
	input wire logic clk,
	input wire logic sampleReq,
	input wire logic [3:0] delay,
	input wire logic [9:0] ratioSet,
	output logic sampleValid,
	output logic [9:0] ratio
);
	logic [3:0] cnt;
	logic busy;
	initial begin
		cnt = 4'h0;
		busy = 1'b0;
		sampleValid = 1'b0;
		ratio = 10'h000;
	end
	// The ratio toggles outside the valid pulse, so a stale result looks right only on every other cycle.
	always @(posedge clk) begin
		sampleValid <= 1'b0;
		ratio <= ~ratio;
		if (busy && cnt == 4'h0) begin
			busy <= 1'b0;
			sampleValid <= 1'b1;
			ratio <= ratioSet;
		end else if (busy) begin
			cnt <= cnt - 4'h1;
		end else if (sampleReq) begin
			busy <= 1'b1;
			cnt <= delay;
		end
	end
endmodule : cmt_therm_model

/* File: verif/cmt_charger_control_tb_top.sv */
/*
 * Self-checking bench of the charger control block with a converter model.
 * Assumes short watchdog and sample periods set through the block's parameters.
 */
`timescale 1ns/10ps
module cmt_charger_control_tb_top;
	import cmt_pkg::*;
	logic clk, rst, regWr, regRd, busValid, aboveMin, belowSleep, batLow, disPin, dieHot;
	logic thShort, tmrExp, chgDone, prmRst, sReq, sValid, buck, chgEn, batSw, supSw, revBlk, wdExp;
	logic [3:0] regAddr, mDelay, code;
	logic [7:0] regWdata, regRdata, rv, f, s;
	logic [9:0] ratio, ratioSet;
	logic [10:0] curMa;
	logic [12:0] fltMv;
	int miscompares, n_compared, n, z;
	// ---------------------------------------------------------------
	// Design and converter
	// ---------------------------------------------------------------
	cmt_charger_control #(.WDOG_CYCLES(64), .THERM_CYCLES(32)) DUT (.clk(clk), .rst(rst),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .busValidPin(busValid), .busAboveMinPin(aboveMin),
		.busBelowSleepPin(belowSleep), .batBelowLowPin(batLow), .disablePin(disPin),
		.dieHotPin(dieHot), .thermShortPin(thShort), .safetyTimerExpired(tmrExp),
		.chargeDone(chgDone), .paramResetReq(prmRst), .thermSampleReq(sReq),
		.thermSampleValid(sValid), .thermRatio(ratio), .buckEnable(buck),
		.chargeEnable(chgEn), .batterySwitchOn(batSw), .supplementSwitchOn(supSw),
		.reverseBlockOn(revBlk), .chargeCurrentMa(curMa), .floatVoltageMv(fltMv),
		.watchdogExpired(wdExp));
	cmt_therm_model conv (.clk(clk), .sampleReq(sReq), .delay(mDelay), .ratioSet(ratioSet),
		.sampleValid(sValid), .ratio(ratio));
	always #20 clk = ~clk;
	// ---------------------------------------------------------------
	// Tasks and expectations
	// ---------------------------------------------------------------
	task automatic final_report();
		if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chkN(input string nm, input logic [12:0] e, input logic [12:0] g);
		n_compared++;
		if (e !== g) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chkN
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rv = regRdata;
	endtask : rd
	task automatic settle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : settle
	task automatic waitWd(input int lim);
		for (n = 0; n < lim && wdExp !== 1'b1; n++) @(posedge clk);
		if (n == lim) begin
			miscompares++;
			$display("mismatch watchdogExpired expected 1 seen 0");
			final_report();
		end
	endtask : waitWd
	function automatic logic [9:0] pickRatio(input int zz);
		case (zz)
			0: pickRatio = 10'($urandom_range(1000, 750));
			1: pickRatio = 10'($urandom_range(735, 650));
			2: pickRatio = 10'($urandom_range(640, 335));
			3: pickRatio = 10'($urandom_range(325, 240));
			default: pickRatio = 10'($urandom_range(228, 0));
		endcase
	endfunction : pickRatio
	function automatic logic [12:0] expCur(input logic [3:0] c, input int zz, input logic td);
		logic [12:0] p;
		p = 13'd350 + 13'd100 * c;
		if (td || zz == 2) expCur = p;
		else if (p < 13'd650) expCur = 13'd340;
		else expCur = p >> 1;
	endfunction : expCur
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		n = $urandom(89454);
		{clk, regWr, regRd, belowSleep, batLow, disPin, dieHot, thShort} = 8'h00;
		{tmrExp, chgDone, prmRst, busValid, aboveMin, rst} = 6'h07;
		{regAddr, regWdata, mDelay} = 16'h0000;
		ratioSet = 10'd500;
		miscompares = 0;
		n_compared = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		settle(8);
		rd(CMT_REG_CTRL); chkN("ctrl reset", 8'h04, rv);
		rd(CMT_REG_WDOG); chkN("wdog reset", 8'h02, rv);
		rd(4'hF); chkN("unmapped", 8'h00, rv);
		rd(CMT_REG_MONITOR); chkN("monitor idle", 8'h09, rv);
		belowSleep <= 1'b1; settle(8); chkN("reverse block", 1, revBlk);
		rd(CMT_REG_MONITOR); chkN("monitor sleep", 1, rv[4]);
		belowSleep <= 1'b0; dieHot <= 1'b1; settle(8); chkN("buck hot", 0, buck);
		rd(CMT_REG_MONITOR); chkN("monitor standby", 1, rv[2]);
		dieHot <= 1'b0; disPin <= 1'b1; settle(8);
		chkN("hiz switches", 3'b011, {buck, batSw, supSw});
		rd(CMT_REG_MONITOR); chkN("monitor hiz valid", 2'b11, rv[1:0]);
		disPin <= 1'b0; settle(8); chkN("buck resume", 1, buck);
		f = 8'($urandom_range(63, 1)) << 2;
		s = 8'($urandom_range(255, 1));
		wr(CMT_REG_FLOAT, f); wr(CMT_REG_SAFETY, s); wr(CMT_REG_CTRL, 8'hFA);
		wr(CMT_REG_LEVEL, 8'h30);
		@(posedge clk); prmRst <= 1'b1; @(posedge clk); prmRst <= 1'b0;
		rd(CMT_REG_FLOAT); chkN("param float", 8'h00, rv);
		rd(CMT_REG_SAFETY); chkN("param safety", 8'h00, rv);
		rd(CMT_REG_LEVEL); chkN("param level", 8'h30, rv);
		rd(CMT_REG_CTRL); chkN("param ctrl", 8'h0A, rv);
		wr(CMT_REG_SAFETY, s); wr(CMT_REG_FLOAT, f); wr(CMT_REG_CURRENT, 8'h80);
		rd(CMT_REG_FLOAT); chkN("reset float", 8'h00, rv);
		rd(CMT_REG_SAFETY); chkN("reset safety", s, rv);
		rd(CMT_REG_LEVEL); chkN("reset level", 8'h00, rv);
		rd(CMT_REG_CTRL); chkN("reset ctrl", 8'h04, rv);
		batLow <= 1'b1; settle(8); wr(CMT_REG_CURRENT, 8'h80);
		rd(CMT_REG_CTRL); chkN("reset low bat", 8'h00, rv);
		batLow <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			z = (i + 2) % 5;
			code = (i % 2) ? 4'($urandom_range(2, 0)) : 4'($urandom_range(15, 3));
			f = 8'($urandom_range(63, 0)) << 2;
			mDelay <= 4'($urandom_range(7, 0));
			ratioSet <= pickRatio(z);
			wr(CMT_REG_CURRENT, {1'b0, code, 3'b000}); wr(CMT_REG_FLOAT, f);
			settle(100);
			rd(CMT_REG_THERM);
			chkN("zone", {4'h1, 4'((16'h0000 + 4'hF) >> (4 - z))}, rv & 8'h1F);
			chkN("charge on", (z > 0 && z < 4), chgEn);
			if (z > 0 && z < 4) begin
				chkN("current", expCur(code, z, 1'b0), curMa);
				chkN("float", (z == 2) ? 13'd3500 + 13'd5 * f : 13'd4000, fltMv);
			end
		end
		ratioSet <= pickRatio(4); wr(CMT_REG_THERM, 8'h20); settle(100);
		chkN("tdis charge", 1, chgEn);
		chkN("tdis current", expCur(code, 4, 1'b1), curMa);
		wr(CMT_REG_CURRENT, 8'h80); rd(CMT_REG_THERM); chkN("tdis cleared", 0, rv[5]);
		thShort <= 1'b1; wr(CMT_REG_CTRL, 8'h00); settle(100);
		rd(CMT_REG_THERM); chkN("short status", 8'h00, rv & 8'h1F);
		chkN("short charge", 1, chgEn);
		thShort <= 1'b0; chgDone <= 1'b1; settle(8);
		chkN("idle", 2'b10, {buck, chgEn});
		chgDone <= 1'b0; wr(CMT_REG_FLOAT, f); wr(CMT_REG_CTRL, 8'h02); settle(8);
		chkN("hiz bit", 0, buck);
		batLow <= 1'b1; settle(8);
		rd(CMT_REG_FLOAT); chkN("lowbat float", 8'h00, rv);
		rd(CMT_REG_CTRL); chkN("lowbat hiz", 0, rv[1]);
		chkN("lowbat buck", 1, buck);
		disPin <= 1'b1; settle(8); chkN("lowbat pin", 0, buck);
		disPin <= 1'b0; batLow <= 1'b0; settle(8);
		wr(CMT_REG_WDOG, 8'h01); wr(CMT_REG_CTRL, 8'h02);
		z = 0;
		repeat (150) begin
			@(posedge clk);
			z += (wdExp === 1'b1);
		end
		chkN("wdog frozen", 0, z);
		wr(CMT_REG_CTRL, 8'h00); waitWd(80);
		chkN("wdog remainder", 1, (n >= 50 && n <= 66));
		wr(CMT_REG_WDOG, 8'h01); wr(CMT_REG_FLOAT, f); wr(CMT_REG_CTRL, 8'h02);
		batLow <= 1'b1; settle(8);
		rd(CMT_REG_FLOAT); chkN("wdog hold", f, rv);
		waitWd(80); settle(4);
		rd(CMT_REG_FLOAT); chkN("wdog reset float", 8'h00, rv);
		rd(CMT_REG_WDOG); chkN("wdog reset dis", 8'h02, rv);
		final_report();
	end
endmodule : cmt_charger_control_tb_top
